// ==== logic/hpc_edge.sv ====
/*
  Rising and falling edge finder on an already synchronised level.
  Assumes the input is in the mclk domain.
*/
`timescale 1ns/100ps
module hpc_edge (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic prev_q;
  logic prev_d;

  always_comb begin
    prev_d = level;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;
endmodule

// ==== logic/hpc_params.svh ====
/*
  Constants of the host port and control pin front end.
  Assumes inclusion by the package and by every design file that needs a count.
*/
// Function
// [R1] The serial host port is an I2C target while the select input is high and an SPI target while it is low.
// [R2] The shared data pin is two-way in I2C and 3-wire SPI modes and only the data input in 4-wire SPI mode.
// [R3] The second shared pin is sampled as address bit 1 in I2C mode and driven as data output in 4-wire SPI mode.
// [R4] The host supplies the serial clock on one input, used as the serial clock in both modes.
// [R5] The third shared pin is address bit 0 in I2C mode and an active-low chip select framing each SPI transaction.
// [R6] The interrupt output is driven low whenever a change in internal status has been detected.
// [R7] While the reset input is low the whole device is reset and every setting returns to its default.
// [R8] All clock outputs stay disabled while reset is in effect.
// [R9] Outputs governed by the first enable input are enabled while it is low and disabled while it is high.
// [R10] After reset the first enable input governs every output; configuration may restrict it to a subset.
// [R11] The second enable input affects no output until configuration assigns it a subset.
// [R12] An output governed by both enable inputs is enabled only while every governing input is low.
`ifndef HPC_PARAMS_SVH
`define HPC_PARAMS_SVH

`define HPC_NUM_OUT        8
`define HPC_OE0_MASK_RST   8'hFF
`define HPC_OE1_MASK_RST   8'h00
`define HPC_I2C_SEL_LEVEL  1'b1
`define HPC_SYNC_RST       1'b0

`endif

// ==== logic/hpc_pkg.sv ====
/*
  Types of the host port and control pin front end.
  Assumes the constants header is on the include path.
*/
`include "hpc_params.svh"
package hpc_pkg;
  typedef enum logic [1:0] {
    HPC_MODE_I2C,
    HPC_MODE_SPI3,
    HPC_MODE_SPI4
  } hpc_mode_e;
  typedef logic [`HPC_NUM_OUT-1:0] hpc_outmask_t;
endpackage

// ==== logic/hpc_sync.sv ====
/*
  Three-stage synchroniser for one pin; the output changes once stages two and three agree.
  Assumes a free running mclk and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module hpc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic pin,
  output logic      level
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       lvl_q;
  logic       lvl_d;

  always_comb begin
    sh_d  = {sh_q[1:0], pin};
    lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sh_q  <= {3{RST_VAL}};
      lvl_q <= RST_VAL;
    end else begin
      sh_q  <= sh_d;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
endmodule

// ==== logic/hpc_top.sv ====
/*
  Pin front end: serial port mode and pin roles, interrupt pin, reset, output enables.
  Assumes the serial engine and status logic sit behind the user-side ports on mclk.
*/
`timescale 1ns/100ps
`include "hpc_params.svh"
module hpc_top
  import hpc_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    device_reset_n,
  input  wire logic                    i2c_select,
  input  wire logic                    serial_clk,
  input  wire logic                    sdio_in,
  output logic                         sdio_out,
  output logic                         sdio_oe,
  input  wire logic                    addr1_or_data_out_in,
  output logic                         addr1_or_data_out_out,
  output logic                         addr1_or_data_out_oe,
  input  wire logic                    addr0_or_select_n,
  output logic                         irq_n,
  input  wire logic                    output_enable_first_n,
  input  wire logic                    output_enable_second_n,
  input  wire logic                    spi_four_wire,
  input  wire logic                    core_data_out,
  input  wire logic                    core_data_drive,
  input  wire logic                    status_change,
  input  wire logic                    irq_clear,
  input  wire logic                    cfg_write,
  input  wire logic [`HPC_NUM_OUT-1:0] cfg_oe0_mask,
  input  wire logic [`HPC_NUM_OUT-1:0] cfg_oe1_mask,
  output logic [1:0]                   port_mode,
  output logic                         ser_clk_rise,
  output logic                         ser_clk_fall,
  output logic                         ser_data_in,
  output logic                         spi_frame,
  output logic [1:0]                   i2c_addr,
  output logic [`HPC_NUM_OUT-1:0]      clk_out_en,
  output logic                         core_rst_b
);
  // =====================================================
  // Reset and pin synchronisers
  logic rst_b;
  logic rst_s1_q;
  logic rst_s2_q;
  logic sel_s;
  logic sck_s;
  logic sdi_s;
  logic a1_s;
  logic cs_s;
  logic oe0_s;
  logic oe1_s;
  logic sck_rise;
  logic sck_fall;

  // Reset pin is itself async; two flops give a clean synchronous release, while the pin asserts reset at once
  always_ff @(posedge mclk) begin
    rst_s1_q <= device_reset_n;
    rst_s2_q <= rst_s1_q;
  end
  assign rst_b = rst_s2_q & device_reset_n; // [R7]

  hpc_sync #(.RST_VAL(1'b1)) u_sync_sel (.mclk(mclk), .rst_b(rst_b), .pin(i2c_select),             .level(sel_s));
  hpc_sync #(.RST_VAL(1'b0)) u_sync_sck (.mclk(mclk), .rst_b(rst_b), .pin(serial_clk),             .level(sck_s));
  hpc_sync #(.RST_VAL(1'b1)) u_sync_sdi (.mclk(mclk), .rst_b(rst_b), .pin(sdio_in),                .level(sdi_s));
  hpc_sync #(.RST_VAL(1'b0)) u_sync_a1  (.mclk(mclk), .rst_b(rst_b), .pin(addr1_or_data_out_in),   .level(a1_s));
  hpc_sync #(.RST_VAL(1'b1)) u_sync_cs  (.mclk(mclk), .rst_b(rst_b), .pin(addr0_or_select_n),      .level(cs_s));
  hpc_sync #(.RST_VAL(1'b1)) u_sync_oe0 (.mclk(mclk), .rst_b(rst_b), .pin(output_enable_first_n),  .level(oe0_s));
  hpc_sync #(.RST_VAL(1'b1)) u_sync_oe1 (.mclk(mclk), .rst_b(rst_b), .pin(output_enable_second_n), .level(oe1_s));

  hpc_edge u_sck_edge (.mclk(mclk), .rst_b(rst_b), .level(sck_s), .rise(sck_rise), .fall(sck_fall));

  // =====================================================
  // Mode and pin roles
  hpc_mode_e    mode_d;
  hpc_mode_e    mode_q;
  logic         rise_d, rise_q, fall_d, fall_q, din_d, din_q, frame_d, frame_q;
  logic [1:0]   addr_d, addr_q;
  logic         sdo_d, sdo_q, sdoe_d, sdoe_q, a1o_d, a1o_q, a1oe_d, a1oe_q;

  always_comb begin
    if (sel_s == `HPC_I2C_SEL_LEVEL) begin
      mode_d = HPC_MODE_I2C; // [R1]
    end else if (spi_four_wire) begin
      mode_d = HPC_MODE_SPI4;
    end else begin
      mode_d = HPC_MODE_SPI3;
    end
    rise_d  = sck_rise; // [R4]
    fall_d  = sck_fall; // [R4]
    din_d   = sdi_s;
    frame_d = (mode_d != HPC_MODE_I2C) && !cs_s; // [R5]
    addr_d  = addr_q;
    sdo_d   = 1'b0;
    sdoe_d  = 1'b0;
    a1o_d   = 1'b0;
    a1oe_d  = 1'b0;
    // Pin roles follow the mode being registered, so roles and mode never disagree
    case (mode_d)
      HPC_MODE_I2C: begin
        addr_d = {a1_s, cs_s}; // [R3] [R5]
        // Open drain: only ever pull low
        sdo_d  = 1'b0;
        sdoe_d = core_data_drive & ~core_data_out; // [R2]
      end
      HPC_MODE_SPI3: begin
        sdo_d  = core_data_out;
        sdoe_d = core_data_drive & ~cs_s; // [R2]
      end
      HPC_MODE_SPI4: begin
        a1o_d  = core_data_out; // [R3]
        a1oe_d = ~cs_s; // [R3]
      end
      default: begin
        sdoe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mode_q  <= HPC_MODE_I2C;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
      din_q   <= 1'b1;
      frame_q <= 1'b0;
      addr_q  <= 2'h0;
      sdo_q   <= 1'b0;
      sdoe_q  <= 1'b0;
      a1o_q   <= 1'b0;
      a1oe_q  <= 1'b0;
    end else begin
      mode_q  <= mode_d;
      rise_q  <= rise_d;
      fall_q  <= fall_d;
      din_q   <= din_d;
      frame_q <= frame_d;
      addr_q  <= addr_d;
      sdo_q   <= sdo_d;
      sdoe_q  <= sdoe_d;
      a1o_q   <= a1o_d;
      a1oe_q  <= a1oe_d;
    end
  end

  // =====================================================
  // Interrupt pin and output enables
  logic                    irq_d, irq_q;
  hpc_outmask_t            m0_d, m0_q, m1_d, m1_q, en_d, en_q;
  logic                    crst_q;

  always_comb begin
    // Set wins over clear
    irq_d = status_change ? 1'b1 : (irq_clear ? 1'b0 : irq_q); // [R6]
    m0_d  = cfg_write ? cfg_oe0_mask : m0_q; // [R10]
    m1_d  = cfg_write ? cfg_oe1_mask : m1_q; // [R11]
    for (int i = 0; i < `HPC_NUM_OUT; i++) begin
      en_d[i] = !(m0_q[i] && oe0_s) && !(m1_q[i] && oe1_s); // [R9] [R12]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq_q  <= 1'b0;
      m0_q   <= `HPC_OE0_MASK_RST; // [R10]
      m1_q   <= `HPC_OE1_MASK_RST; // [R11]
      en_q   <= '0; // [R8]
      crst_q <= `HPC_SYNC_RST;
    end else begin
      irq_q  <= irq_d;
      m0_q   <= m0_d;
      m1_q   <= m1_d;
      en_q   <= en_d;
      crst_q <= 1'b1;
    end
  end

  assign port_mode             = mode_q;
  assign ser_clk_rise          = rise_q;
  assign ser_clk_fall          = fall_q;
  assign ser_data_in           = din_q;
  assign spi_frame             = frame_q;
  assign i2c_addr              = addr_q;
  assign sdio_out              = sdo_q;
  assign sdio_oe               = sdoe_q;
  assign addr1_or_data_out_out = a1o_q;
  assign addr1_or_data_out_oe  = a1oe_q;
  assign irq_n                 = ~irq_q;
  assign clk_out_en            = en_q;
  assign core_rst_b            = crst_q;

  // =====================================================
  // Checks
  property p_mode_i2c;
    @(posedge mclk) disable iff (!rst_b) (sel_s == 1'b1) |=> (mode_q == HPC_MODE_I2C);
  endproperty
  a_mode_i2c: assert property (p_mode_i2c) else $error("I2C mode not taken"); // [R1]

  property p_sdo_only_spi4;
    @(posedge mclk) disable iff (!rst_b) addr1_or_data_out_oe |-> (mode_q == HPC_MODE_SPI4);
  endproperty
  a_sdo_only_spi4: assert property (p_sdo_only_spi4) else $error("Data out driven outside 4-wire"); // [R3]

  property p_sdio_quiet_spi4;
    @(posedge mclk) disable iff (!rst_b) (mode_q == HPC_MODE_SPI4) |-> !sdio_oe;
  endproperty
  a_sdio_quiet_spi4: assert property (p_sdio_quiet_spi4) else $error("Data pin driven in 4-wire"); // [R2]

  property p_sck_follow;
    @(posedge mclk) disable iff (!rst_b) sck_rise |=> ser_clk_rise;
  endproperty
  a_sck_follow: assert property (p_sck_follow) else $error("Serial clock edge lost"); // [R4]

  property p_frame;
    @(posedge mclk) disable iff (!rst_b) spi_frame |-> (mode_q != HPC_MODE_I2C);
  endproperty
  a_frame: assert property (p_frame) else $error("Frame in I2C mode"); // [R5]

  property p_irq;
    @(posedge mclk) disable iff (!rst_b) status_change |=> !irq_n;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt not asserted"); // [R6]

  property p_rst_off;
    @(posedge mclk) !rst_b |=> (clk_out_en == '0) && (m0_q == `HPC_OE0_MASK_RST);
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("Outputs live after reset"); // [R7] [R8]

  property p_oe0_off;
    @(posedge mclk) disable iff (!rst_b) (oe0_s && (m0_q == `HPC_OE0_MASK_RST)) |=> (clk_out_en == '0);
  endproperty
  a_oe0_off: assert property (p_oe0_off) else $error("Enable high left outputs on"); // [R9] [R10]

  property p_oe1_none;
    @(posedge mclk) disable iff (!rst_b) (!oe0_s && (m1_q == '0)) |=> (clk_out_en == '1);
  endproperty
  a_oe1_none: assert property (p_oe1_none) else $error("Second enable acted unassigned"); // [R11] [R12]
endmodule

// ==== tb/hpc_host_model.sv ====
/*
  Host controller model: serial clock, chip select and data toward the port.
  Assumes the bench resolves the shared data wire from both drivers.
*/
`timescale 1ns/100ps
module hpc_host_model (
  output logic sclk,
  output logic cs_n,
  output logic dat
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dat  = 1'b1;
  end
  // ==========================================
  // Frame: clock only moves inside a frame
  task automatic frame(input int nbits, input logic [31:0] pat);
    // Keep pin changes off the sampling edge
    #2;
    cs_n = 1'b0;
    #100;
    for (int i = 0; i < nbits; i++) begin
      dat = pat[i];
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
    dat = ~dat;
    #100 cs_n = 1'b1;
  endtask
endmodule

// ==== tb/tb_host_port_and_control_pins.sv ====
/*
  Self-checking bench of the pin front end against a behavioural model.
  Assumes hpc_top and hpc_host_model are compiled first.
*/
`timescale 1ns/100ps
module tb_host_port_and_control_pins;
  import hpc_pkg::*;
  logic         mclk, dev_rst_n, i2c_sel, a1_in, a0_i2c, oe0_n, oe1_n, four_w;
  logic         c_dat, c_drv, st_chg, irq_clr, cfg_wr, sdio_out, sdio_oe, a1_out, a1_oe;
  logic         irq_n, s_rise, s_fall, s_din, spi_frame, core_rst_b, h_sclk, h_cs_n, h_dat;
  logic [1:0]   port_mode, i2c_addr;
  logic [31:0]  r;
  hpc_outmask_t m0, m1, clk_en;
  int           n_mismatch, n_compared, n_rise, n_fall;
  int           seed = 32'h675cf1cc;
  // ==========================================
  // Design and host
  hpc_host_model host (.sclk(h_sclk), .cs_n(h_cs_n), .dat(h_dat));
  hpc_top uut (
    .mclk(mclk), .device_reset_n(dev_rst_n), .i2c_select(i2c_sel), .serial_clk(h_sclk),
    .sdio_in(sdio_oe ? sdio_out : h_dat), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .addr1_or_data_out_in(a1_in), .addr1_or_data_out_out(a1_out), .addr1_or_data_out_oe(a1_oe),
    .addr0_or_select_n(i2c_sel ? a0_i2c : h_cs_n), .irq_n(irq_n), .output_enable_first_n(oe0_n),
    .output_enable_second_n(oe1_n), .spi_four_wire(four_w), .core_data_out(c_dat),
    .core_data_drive(c_drv), .status_change(st_chg), .irq_clear(irq_clr), .cfg_write(cfg_wr),
    .cfg_oe0_mask(m0), .cfg_oe1_mask(m1), .port_mode(port_mode), .ser_clk_rise(s_rise),
    .ser_clk_fall(s_fall), .ser_data_in(s_din), .spi_frame(spi_frame), .i2c_addr(i2c_addr),
    .clk_out_en(clk_en), .core_rst_b(core_rst_b));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (s_rise === 1'b1) n_rise++;
  always @(posedge mclk) if (s_fall === 1'b1) n_fall++;
  // ==========================================
  // Model and helpers
  function automatic hpc_outmask_t exp_en(hpc_outmask_t a, hpc_outmask_t b, logic o0, logic o1);
    for (int i = 0; i < `HPC_NUM_OUT; i++) exp_en[i] = !((a[i] & o0) | (b[i] & o1));
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    end_sim;
  end
  // ==========================================
  // Main sequence
  initial begin
    {dev_rst_n, a1_in, a0_i2c, oe0_n, four_w, c_dat, c_drv, irq_clr, cfg_wr} = '0;
    {i2c_sel, oe1_n, st_chg} = 3'h7;
    m0 = 8'h00;
    m1 = 8'h00;
    cyc(20);
    chk(clk_en, 8'h00, "outputs on in reset");
    chk({irq_n, core_rst_b, a1_oe}, 3'h4, "reset state");
    dev_rst_n <= 1'b1;
    st_chg <= 1'b0;
    cyc(10);
    chk({irq_n, core_rst_b}, 2'h3, "after reset");
    chk(clk_en, 8'hFF, "default enables");
    oe0_n <= 1'b1;
    cyc(8);
    chk(clk_en, 8'h00, "first enable high");
    for (int k = 0; k < 4; k++) begin
      a1_in <= k[1];
      a0_i2c <= k[0];
      cyc(8);
      chk(i2c_addr, k[1:0], "i2c address");
      chk({port_mode, a1_oe}, 3'h0, "i2c mode");
    end
    i2c_sel <= 1'b0;
    c_drv <= 1'b1;
    for (int fw = 0; fw < 2; fw++) begin
      r = $random(seed);
      four_w <= fw[0];
      c_dat <= r[9];
      n_rise = 0;
      n_fall = 0;
      fork
        host.frame(8, r);
        begin
          cyc(30);
          chk({spi_frame, port_mode}, {1'b1, 2'(fw + 1)}, "spi mode");
          chk({sdio_oe, a1_oe}, {!fw[0], fw[0]}, "pin roles");
          chk(fw ? a1_out : sdio_out, r[9], "data out");
        end
      join
      cyc(12);
      chk(n_rise, 32'd8, "rising clock edges");
      chk(n_fall, 32'd8, "falling clock edges");
      chk(spi_frame, 1'b0, "frame closed");
      chk(s_din, h_dat, "data pin input");
    end
    st_chg <= 1'b1;
    cyc(1);
    st_chg <= 1'b0;
    cyc(2);
    chk(irq_n, 1'b0, "irq set");
    {st_chg, irq_clr} <= 2'h3;
    cyc(1);
    {st_chg, irq_clr} <= 2'h0;
    cyc(2);
    chk(irq_n, 1'b0, "set wins");
    irq_clr <= 1'b1;
    cyc(1);
    irq_clr <= 1'b0;
    cyc(2);
    chk(irq_n, 1'b1, "irq cleared");
    repeat (40) begin
      r = $random(seed);
      m0 <= r[7:0];
      m1 <= r[15:8];
      oe0_n <= r[16];
      oe1_n <= r[17];
      cfg_wr <= 1'b1;
      cyc(1);
      cfg_wr <= 1'b0;
      cyc(8);
      chk(clk_en, exp_en(m0, m1, oe0_n, oe1_n), "enable subsets");
    end
    dev_rst_n <= 1'b0;
    cyc(4);
    chk(clk_en, 8'h00, "outputs on in second reset");
    dev_rst_n <= 1'b1;
    cyc(10);
    chk(clk_en, exp_en(8'hFF, 8'h00, oe0_n, oe1_n), "masks restored");
    end_sim;
  end
endmodule
